// [hw/sbu_pkg.sv]
// Shared types and constants of the shift and bit manipulation unit
package sbu_pkg;

	localparam int unsigned BYTE_W = 8;
	localparam int unsigned BITNO_W = 3;
	localparam int unsigned ADDR_W = 16;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [2:0] SIGN_POS = 3'h7;

	// Operation codes
	typedef enum logic [4:0] {
		arith_shift_left_op,
		arith_shift_right_op,
		logic_shift_left_op,
		logic_shift_right_op,
		rotate_left_op,
		rotate_right_op,
		rotate_carry_left_op,
		rotate_carry_right_op,
		bit_set_op,
		bit_clear_op,
		bit_invert_op,
		bit_test_op,
		carry_and_bit_op,
		carry_and_inv_bit_op,
		carry_or_bit_op,
		carry_or_inv_bit_op,
		carry_xor_bit_op,
		carry_xor_inv_bit_op,
		bit_to_carry_op,
		inv_bit_to_carry_op,
		carry_to_bit_op,
		inv_carry_to_bit_op
	} sbu_op_e;

	// Flag bits of condition_flags touched by this unit
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} sbu_flags_s;

	// One operation request from the core
	typedef struct packed {
		sbu_op_e op;
		logic to_mem;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] reg_data;
		logic bit_from_reg;
		logic [BITNO_W-1:0] bit_imm;
		logic [BYTE_W-1:0] bit_reg;
		sbu_flags_s flags;
	} sbu_req_s;

	// Outcome reported with done
	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic data_we;
		sbu_flags_s flags;
		sbu_flags_s flags_we;
	} sbu_res_s;

endpackage

// [hw/sbu_unit.sv]
// Shift and bit manipulation datapath with memory read-modify-write
`timescale 1ns/1ps

// What this block does
// RULE1: Arithmetic shift left or right of register
// RULE2: Logical shift left or right of register
// RULE3: Rotate register byte without carry
// RULE4: Rotate through carry as ninth bit
// RULE5: Bit set forces selected bit to one
// RULE6: Bit clear forces selected bit to zero
// RULE7: Bit invert complements selected bit only
// RULE8: Bit test loads zero with inverted bit
// RULE9: Bit number from immediate or register
// RULE10: Carry becomes carry AND bit
// RULE11: Carry becomes carry AND inverted bit
// RULE12: Carry becomes carry OR bit
// RULE13: Carry becomes carry OR inverted bit
// RULE14: Carry becomes carry XOR bit
// RULE15: Carry becomes carry XOR inverted bit
// RULE16: Bit load copies bit to carry
// RULE17: Inverted bit load copies inverted bit
// RULE18: Bit store writes carry into bit
// RULE19: Inverted bit store writes inverted carry
// RULE20: Carry bit ops use immediate bit number
// RULE21: Shifted-out bit to carry, sign handling
// RULE22: Memory targets use full-byte read-modify-write
module sbu_unit (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Request from the core
	input wire logic req_valid_i,
	input wire sbu_pkg::sbu_req_s req_i,
	output logic req_ready_o,
	// Completion
	output logic done_o,
	output sbu_pkg::sbu_res_s res_o,
	// Memory byte port
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [sbu_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [sbu_pkg::BYTE_W-1:0] mem_wdata_o,
	input wire logic [sbu_pkg::BYTE_W-1:0] mem_rdata_i,
	input wire logic mem_ack_i
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} sbu_st_e;

	typedef struct packed {
		sbu_st_e st;
		logic ready;
		logic done;
		sbu_pkg::sbu_res_s res;
		logic mem_rd;
		logic mem_wr;
		logic [sbu_pkg::ADDR_W-1:0] addr;
		logic [sbu_pkg::BYTE_W-1:0] wdata;
		sbu_pkg::sbu_op_e op;
		logic [sbu_pkg::BITNO_W-1:0] bitno;
		sbu_pkg::sbu_flags_s flags;
	} sbu_state_s;

	sbu_state_s state;
	sbu_state_s next_state;

	// Shifts and rotates sit at the bottom of the op list
	function automatic logic is_shift(input sbu_pkg::sbu_op_e op);
		is_shift = (op <= sbu_pkg::rotate_carry_right_op);
	endfunction

	// Listed one by one so a reordered op list cannot widen the set
	function automatic logic writes_carry(input sbu_pkg::sbu_op_e op);
		unique case (op)
			sbu_pkg::carry_and_bit_op, sbu_pkg::carry_and_inv_bit_op,
			sbu_pkg::carry_or_bit_op, sbu_pkg::carry_or_inv_bit_op,
			sbu_pkg::carry_xor_bit_op, sbu_pkg::carry_xor_inv_bit_op,
			sbu_pkg::bit_to_carry_op, sbu_pkg::inv_bit_to_carry_op: writes_carry = 1'b1;
			default: writes_carry = 1'b0;
		endcase
	endfunction

	// Idle and ready, everything else cleared
	function automatic sbu_state_s idle_state();
		sbu_state_s s;
		s = '0;
		s.st = ST_IDLE;
		s.ready = 1'b1;
		return s;
	endfunction

	// Carry-combining and carry-move ops ignore a register bit number
	function automatic logic imm_only(input sbu_pkg::sbu_op_e op);
		unique case (op)
			sbu_pkg::carry_and_bit_op, sbu_pkg::carry_and_inv_bit_op,
			sbu_pkg::carry_or_bit_op, sbu_pkg::carry_or_inv_bit_op,
			sbu_pkg::carry_xor_bit_op, sbu_pkg::carry_xor_inv_bit_op,
			sbu_pkg::bit_to_carry_op, sbu_pkg::inv_bit_to_carry_op,
			sbu_pkg::carry_to_bit_op, sbu_pkg::inv_carry_to_bit_op: imm_only = 1'b1; // RULE20
			default: imm_only = 1'b0;
		endcase
	endfunction

	// Ops that change the operand byte
	function automatic logic writes_byte(input sbu_pkg::sbu_op_e op);
		unique case (op)
			sbu_pkg::bit_set_op, sbu_pkg::bit_clear_op, sbu_pkg::bit_invert_op,
			sbu_pkg::carry_to_bit_op, sbu_pkg::inv_carry_to_bit_op: writes_byte = 1'b1;
			default: writes_byte = is_shift(op);
		endcase
	endfunction

	// Register bit number only where the op allows one
	function automatic logic [sbu_pkg::BITNO_W-1:0] pick_bitno(input sbu_pkg::sbu_req_s rq);
		logic [sbu_pkg::BITNO_W-1:0] n;
		if (rq.bit_from_reg && !imm_only(rq.op)) begin
			n = rq.bit_reg[sbu_pkg::BITNO_W-1:0]; // RULE9
		end else begin
			n = rq.bit_imm; // RULE9 RULE20
		end
		return n;
	endfunction

	// Byte with one bit replaced and the other seven kept
	function automatic logic [sbu_pkg::BYTE_W-1:0] put_bit(
		input logic [sbu_pkg::BYTE_W-1:0] d,
		input logic [sbu_pkg::BITNO_W-1:0] bn,
		input logic v
	);
		logic [sbu_pkg::BYTE_W-1:0] q;
		q = d;
		q[bn] = v;
		return q;
	endfunction

	// Sign and zero of the shifted byte; overflow is always cleared
	function automatic sbu_pkg::sbu_flags_s shift_flags(
		input logic [sbu_pkg::BYTE_W-1:0] q,
		input logic c
	);
		sbu_pkg::sbu_flags_s f;
		f.n = q[sbu_pkg::SIGN_POS];
		f.z = (q == sbu_pkg::BYTE_ZERO);
		f.v = 1'b0;
		f.c = c;
		return f;
	endfunction

	// Whole datapath for one byte
	function automatic sbu_pkg::sbu_res_s compute(
		input sbu_pkg::sbu_op_e op,
		input logic [sbu_pkg::BYTE_W-1:0] d,
		input logic [sbu_pkg::BITNO_W-1:0] bn,
		input sbu_pkg::sbu_flags_s f
	);
		sbu_pkg::sbu_res_s r;
		logic b;
		logic shift;
		r = '0;
		r.data = d;
		r.flags = f;
		b = d[bn];
		shift = 1'b1;
		unique case (op)
			sbu_pkg::arith_shift_left_op: begin
				r.data = {d[sbu_pkg::BYTE_W-2:0], 1'b0}; // RULE1
				r.flags.c = d[sbu_pkg::SIGN_POS]; // RULE21
			end
			sbu_pkg::arith_shift_right_op: begin
				r.data = {d[sbu_pkg::SIGN_POS], d[sbu_pkg::BYTE_W-1:1]}; // RULE1 RULE21
				r.flags.c = d[0]; // RULE21
			end
			sbu_pkg::logic_shift_left_op: begin
				r.data = {d[sbu_pkg::BYTE_W-2:0], 1'b0}; // RULE2
				r.flags.c = d[sbu_pkg::SIGN_POS]; // RULE21
			end
			sbu_pkg::logic_shift_right_op: begin
				r.data = {1'b0, d[sbu_pkg::BYTE_W-1:1]}; // RULE2 RULE21
				r.flags.c = d[0]; // RULE21
			end
			sbu_pkg::rotate_left_op: begin
				r.data = {d[sbu_pkg::BYTE_W-2:0], d[sbu_pkg::SIGN_POS]}; // RULE3
				r.flags.c = d[sbu_pkg::SIGN_POS];
			end
			sbu_pkg::rotate_right_op: begin
				r.data = {d[0], d[sbu_pkg::BYTE_W-1:1]}; // RULE3
				r.flags.c = d[0];
			end
			sbu_pkg::rotate_carry_left_op: begin
				r.data = {d[sbu_pkg::BYTE_W-2:0], f.c}; // RULE4
				r.flags.c = d[sbu_pkg::SIGN_POS]; // RULE4
			end
			sbu_pkg::rotate_carry_right_op: begin
				r.data = {f.c, d[sbu_pkg::BYTE_W-1:1]}; // RULE4
				r.flags.c = d[0]; // RULE4
			end
			default: shift = 1'b0;
		endcase
		if (shift) begin
			r.flags = shift_flags(r.data, r.flags.c); // RULE21
			r.flags_we = '1;
		end else begin
			unique case (op)
				sbu_pkg::bit_set_op: r.data = put_bit(d, bn, 1'b1); // RULE5
				sbu_pkg::bit_clear_op: r.data = put_bit(d, bn, 1'b0); // RULE6
				sbu_pkg::bit_invert_op: r.data = put_bit(d, bn, ~b); // RULE7
				sbu_pkg::bit_test_op: begin
					r.flags.z = ~b; // RULE8
					r.flags_we.z = 1'b1;
				end
				sbu_pkg::carry_and_bit_op: r.flags.c = f.c & b; // RULE10
				sbu_pkg::carry_and_inv_bit_op: r.flags.c = f.c & ~b; // RULE11
				sbu_pkg::carry_or_bit_op: r.flags.c = f.c | b; // RULE12
				sbu_pkg::carry_or_inv_bit_op: r.flags.c = f.c | ~b; // RULE13
				sbu_pkg::carry_xor_bit_op: r.flags.c = f.c ^ b; // RULE14
				sbu_pkg::carry_xor_inv_bit_op: r.flags.c = f.c ^ ~b; // RULE15
				sbu_pkg::bit_to_carry_op: r.flags.c = b; // RULE16
				sbu_pkg::inv_bit_to_carry_op: r.flags.c = ~b; // RULE17
				sbu_pkg::carry_to_bit_op: r.data = put_bit(d, bn, f.c); // RULE18
				sbu_pkg::inv_carry_to_bit_op: r.data = put_bit(d, bn, ~f.c); // RULE19
				default: r.data = d;
			endcase
			if (writes_carry(op)) begin
				r.flags_we.c = 1'b1;
			end
		end
		r.data_we = writes_byte(op);
		return r;
	endfunction

	always_comb begin
		sbu_pkg::sbu_res_s calc;
		calc = '0;
		next_state = state;
		next_state.done = 1'b0;
		case (state.st)
			ST_IDLE: begin
				if (req_valid_i) begin
					next_state.op = req_i.op;
					next_state.flags = req_i.flags;
					next_state.bitno = pick_bitno(req_i); // RULE9 RULE20
					// Shifts only ever target a register
					if (req_i.to_mem && !is_shift(req_i.op)) begin
						next_state.st = ST_READ; // RULE22
						next_state.ready = 1'b0;
						next_state.mem_rd = 1'b1;
						next_state.addr = req_i.addr;
					end else begin
						next_state.res = compute(req_i.op, req_i.reg_data,
							next_state.bitno, req_i.flags);
						next_state.done = 1'b1;
					end
				end
			end
			ST_READ: begin
				if (mem_ack_i) begin
					calc = compute(state.op, mem_rdata_i, state.bitno, state.flags);
					next_state.mem_rd = 1'b0;
					next_state.res = calc;
					// Byte goes back to memory, not to a register
					next_state.res.data_we = 1'b0;
					if (calc.data_we) begin
						next_state.st = ST_WRITE; // RULE22
						next_state.mem_wr = 1'b1;
						next_state.wdata = calc.data; // RULE22
					end else begin
						next_state.st = ST_IDLE;
						next_state.ready = 1'b1;
						next_state.done = 1'b1;
					end
				end
			end
			ST_WRITE: begin
				if (mem_ack_i) begin
					next_state.st = ST_IDLE;
					next_state.mem_wr = 1'b0;
					next_state.ready = 1'b1;
					next_state.done = 1'b1;
				end
			end
			default: begin
				next_state = idle_state();
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= idle_state();
		end else begin
			state <= next_state;
		end
	end

	assign req_ready_o = state.ready;
	assign done_o = state.done;
	assign res_o = state.res;
	assign mem_rd_o = state.mem_rd;
	assign mem_wr_o = state.mem_wr;
	assign mem_addr_o = state.addr;
	assign mem_wdata_o = state.wdata;

endmodule // sbu_unit

// [sim/sbu_unit_sva.sv]
// Assertion checker for the shift and bit unit
`timescale 1ns/1ps
module sbu_unit_sva (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Request and completion
	input wire logic req_valid_i,
	input wire sbu_pkg::sbu_req_s req_i,
	input wire logic req_ready_o,
	input wire logic done_o,
	input wire sbu_pkg::sbu_res_s res_o,
	// Memory port
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_ack_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [7:0] rd_q;
	logic sh_q;
	wire take = req_valid_i && req_ready_o;
	// Op kind of the request in flight, for the flag check at done
	always_ff @(posedge clk_i) begin
		if (take) sh_q <= req_i.op < sbu_pkg::bit_set_op;
		if (mem_rd_o && mem_ack_i) rd_q <= mem_rdata_i;
	end
	sequence s_rd_ack;
		mem_rd_o && mem_ack_i;
	endsequence
	sequence s_wr_ack;
		mem_wr_o && mem_ack_i;
	endsequence
	property p_reg_done;
		take && !req_i.to_mem |=> done_o;
	endproperty
	a_reg_done: assert property (p_reg_done) else $error("register op not done in one cycle");
	property p_shift_reg;
		take && req_i.op < sbu_pkg::bit_set_op |=> done_o && !mem_rd_o && res_o.data_we;
	endproperty
	a_shift_reg: assert property (p_shift_reg) else $error("shift did not go to the register");
	property p_take_mem;
		take && req_i.to_mem && req_i.op >= sbu_pkg::bit_set_op
			|=> !req_ready_o && mem_rd_o && mem_addr_o == $past(req_i.addr);
	endproperty
	a_take_mem: assert property (p_take_mem) else $error("memory op did not start a read");
	property p_rd_hold;
		mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read request dropped early");
	property p_wr_hold;
		mem_wr_o && !mem_ack_i |=> mem_wr_o && $stable(mem_wdata_o) && $stable(mem_addr_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write request changed early");
	property p_rd_next;
		s_rd_ack |=> !mem_rd_o && (mem_wr_o || done_o);
	endproperty
	a_rd_next: assert property (p_rd_next) else $error("no step after read ack");
	property p_one_bit;
		s_rd_ack ##1 mem_wr_o |-> $countones(mem_wdata_o ^ rd_q) <= 1;
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("write changed more than one bit");
	property p_wr_done;
		s_wr_ack |=> done_o && !mem_wr_o;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("no done after write ack");
	property p_shift_flags;
		done_o && sh_q |-> res_o.flags_we == 4'hF && !res_o.flags.v
			&& res_o.flags.n == res_o.data[7] && res_o.flags.z == (res_o.data == 8'h00);
	endproperty
	a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");
endmodule // sbu_unit_sva

bind sbu_unit sbu_unit_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
	.req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .res_o(res_o),
	.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
	.mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));

// [sim/sbu_unit_tb.sv]
// Self-checking bench for the shift and bit unit
`timescale 1ns/1ps
module sbu_unit_tb;
	logic clk_i = 0, rst_b_i = 0, req_valid_i = 0, mem_ack_i = 0;
	logic req_ready_o, done_o, mem_rd_o, mem_wr_o;
	logic [15:0] mem_addr_o;
	logic [7:0] mem_wdata_o, wr_seen, mem_rdata_i = 8'h00, mem_byte = 8'h00;
	sbu_pkg::sbu_req_s req_i = '0;
	sbu_pkg::sbu_res_s res_o;
	int error_cnt = 0, tests_run = 0, wr_n = 0;
	always #25 clk_i = ~clk_i;
	sbu_unit uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.req_ready_o(req_ready_o), .done_o(done_o), .res_o(res_o), .mem_rd_o(mem_rd_o),
		.mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
	// Slow memory; read data is junk outside the ack cycle
	always @(posedge clk_i) begin
		mem_ack_i <= (mem_rd_o || mem_wr_o) && !mem_ack_i;
		mem_rdata_i <= (mem_rd_o && !mem_ack_i) ? mem_byte : ~mem_byte;
		if (mem_wr_o && mem_ack_i) begin
			wr_seen <= mem_wdata_o;
			wr_n <= wr_n + 1;
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic sbu_pkg::sbu_res_s model(sbu_pkg::sbu_op_e op, logic [7:0] d,
		logic [2:0] b, logic c);
		sbu_pkg::sbu_res_s e;
		logic x;
		e = '0;
		e.data = d;
		e.flags.c = c;
		x = d[b];
		e.flags_we = 4'h1;
		case (op)
			sbu_pkg::arith_shift_left_op, sbu_pkg::logic_shift_left_op: {e.flags.c, e.data} = {d, 1'b0};
			sbu_pkg::arith_shift_right_op: {e.data, e.flags.c} = {d[7], d};
			sbu_pkg::logic_shift_right_op: {e.data, e.flags.c} = {1'b0, d};
			sbu_pkg::rotate_left_op: {e.flags.c, e.data} = {d, d[7]};
			sbu_pkg::rotate_right_op: {e.data, e.flags.c} = {d[0], d};
			sbu_pkg::rotate_carry_left_op: {e.flags.c, e.data} = {d, c};
			sbu_pkg::rotate_carry_right_op: {e.data, e.flags.c} = {c, d};
			sbu_pkg::bit_set_op: e.data[b] = 1'b1;
			sbu_pkg::bit_clear_op: e.data[b] = 1'b0;
			sbu_pkg::bit_invert_op: e.data[b] = ~x;
			sbu_pkg::bit_test_op: {e.flags.z, e.flags_we} = {~x, 4'h4};
			sbu_pkg::carry_and_bit_op: e.flags.c = c & x;
			sbu_pkg::carry_and_inv_bit_op: e.flags.c = c & ~x;
			sbu_pkg::carry_or_bit_op: e.flags.c = c | x;
			sbu_pkg::carry_or_inv_bit_op: e.flags.c = c | ~x;
			sbu_pkg::carry_xor_bit_op: e.flags.c = c ^ x;
			sbu_pkg::carry_xor_inv_bit_op: e.flags.c = c ^ ~x;
			sbu_pkg::bit_to_carry_op: e.flags.c = x;
			sbu_pkg::inv_bit_to_carry_op: e.flags.c = ~x;
			sbu_pkg::carry_to_bit_op: e.data[b] = c;
			default: e.data[b] = ~c;
		endcase
		if (op < sbu_pkg::bit_set_op) begin
			e.flags_we = 4'hF;
			e.flags.n = e.data[7];
			e.flags.z = e.data == 8'h00;
		end
		if (op inside {[sbu_pkg::bit_set_op:sbu_pkg::bit_invert_op]} || op > 5'd19)
			e.flags_we = 4'h0;
		e.data_we = op inside {[0:10], 20, 21};
		return e;
	endfunction
	task automatic run(input sbu_pkg::sbu_op_e op, input logic m, input logic [7:0] d,
		input logic [2:0] b, input logic fr, input logic c);
		sbu_pkg::sbu_res_s e;
		int n0;
		logic mm;
		// Shifts never go to memory; they work on the register byte
		mm = m && op >= sbu_pkg::bit_set_op;
		// Register bit number only for set, clear, invert and test
		e = model(op, (m && !mm) ? ~d : d, (fr && op inside {[8:11]}) ? ~b : b, c);
		n0 = wr_n;
		@(posedge clk_i);
		#1;
		mem_byte = d;
		req_i = '{op, m, {d, ~d}, m ? ~d : d, fr, b, {5'h15, ~b}, {3'h5, c}};
		req_valid_i = 1'b1;
		@(posedge clk_i);
		#1 req_valid_i = 1'b0;
		repeat (20) if (done_o !== 1'b1) begin @(posedge clk_i); #1; end
		chk("done", 8'h01, 8'(done_o));
		chk("flags_we", 8'(e.flags_we), 8'(res_o.flags_we));
		chk("flags", 8'(e.flags & e.flags_we), 8'(res_o.flags & e.flags_we));
		chk("data_we", 8'(e.data_we && !mm), 8'(res_o.data_we));
		if (m) chk("writes", 8'(e.data_we && mm), 8'(wr_n - n0));
		if (e.data_we) chk("data", e.data, mm ? wr_seen : res_o.data);
	endtask
	task automatic t_reset;
		chk("ready", 8'h01, 8'(req_ready_o));
		chk("idle", 8'h00, {6'h00, mem_rd_o, mem_wr_o});
	endtask
	task automatic t_reg;
		for (int o = 0; o < 22; o++)
			for (int k = 0; k < 32; k++)
				run(sbu_pkg::sbu_op_e'(o), 1'b0, 8'(k * 37), 3'(k), k[3], k[4]);
	endtask
	task automatic t_mem;
		for (int o = 0; o < 22; o++)
			for (int k = 0; k < 32; k++)
				run(sbu_pkg::sbu_op_e'(o), 1'b1, 8'(k * 91) ^ 8'hFF, 3'(k), k[3], k[4]);
	endtask
	task automatic finish_test;
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		t_reset;
		t_reg;
		t_mem;
		finish_test;
	end
	// About five times the expected run
	initial begin
		#1000000;
		error_cnt++;
		finish_test;
	end
endmodule // sbu_unit_tb
